/* lrap_host_model.sv */
// bus master model that drives the serial clock and pulls the data line
`timescale 1ns/1ns
module lrap_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // data moves only while the clock is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        wt(5);
        sda_pull = ~b;
        wt(5);
        scl = 1'b1;
        wt(10);
        r = sda_line;
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        wt(5);
        sda_pull = 1'b0;
        wt(5);
        scl = 1'b1;
        wt(10);
        sda_pull = 1'b1;
        wt(10);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        wt(5);
        sda_pull = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(10);
        sda_pull = 1'b0;
        wt(10);
    endtask : stop
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask : xbyte
endmodule : lrap_host_model

/* lrap_pkg.sv */
// shared constants, states and state records of the display memory pointer block
package lrap_pkg;
    // ------------------------------------------------------------
    // display memory geometry
    // ------------------------------------------------------------
    localparam logic [6:0] COL_LAST = 7'h65;
    localparam logic [3:0] BANK_LAST = 4'h8;
    localparam logic [9:0] MEM_COLS = 10'h066;
    localparam int MEM_WORDS = 918;
    localparam logic [7:0] LAST_BANK_MASK = 8'h01;
    // ------------------------------------------------------------
    // serial bus framing and command decode
    // ------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h1E;
    localparam int CTRL_CO_BIT = 7;
    localparam int CTRL_DC_BIT = 6;
    localparam logic [2:0] CMD_FSET = 3'h1;
    localparam logic [3:0] CMD_SET_BANK = 4'h4;
    localparam int FS_MIRROR_BIT = 4;
    localparam int FS_MY_BIT = 3;
    localparam int FS_PD_BIT = 2;
    localparam int FS_V_BIT = 1;
    localparam int ST_PD_BIT = 7;
    localparam int ST_MIRROR_BIT = 2;
    localparam int ST_MY_BIT = 1;
    localparam logic SDA_DRIVE_LVL = 1'b0;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_MIRROR = 1'b0;
    localparam logic RST_VERT = 1'b0;
    localparam logic RST_PD = 1'b0;
    localparam logic [3:0] SYNC_IDLE = 4'h3;

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_AACK = 8'h04,
        S_RECV = 8'h08,
        S_RACK = 8'h10,
        S_SEND = 8'h20,
        S_MACK = 8'h40,
        S_WAIT = 8'h80
    } lrap_bus_state_e;

    typedef struct packed {
        lrap_bus_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic scl_p;
        logic sda_p;
        logic rw;
        logic dc;
        logic co;
        logic ctrl_next;
        logic [6:0] col;
        logic [3:0] bank;
        logic mirror;
        logic my;
        logic vert;
        logic pd;
        logic oe;
        logic req_seen;
        logic ans_tgl;
        logic [7:0] ans_data;
    } lrap_host_s;

    typedef struct packed {
        logic started;
        logic req_tgl;
        logic ans_seen;
        logic [6:0] col;
        logic [3:0] bank;
        logic [6:0] o_col;
        logic [3:0] o_bank;
        logic [7:0] o_data;
        logic o_stb;
    } lrap_disp_s;

    localparam lrap_host_s HOST_RST = '{st: S_IDLE, mirror: RST_MIRROR, vert: RST_VERT, pd: RST_PD,
                                        scl_p: 1'b1, sda_p: 1'b1, default: '0};
    localparam lrap_disp_s DISP_RST = '{default: '0};
endpackage : lrap_pkg

/* lrap_ptr_step.sv */
// next column and bank pointer after one display memory byte access
`timescale 1ns/1ns
module lrap_ptr_step
    import lrap_pkg::*;
(
    input wire logic [6:0] col,
    input wire logic [3:0] bank,
    input wire logic vert,
    output logic [6:0] col_nxt,
    output logic [3:0] bank_nxt
);
    always_comb begin
        col_nxt = col;
        bank_nxt = bank;
        if (col == COL_LAST && bank == BANK_LAST) begin
            col_nxt = '0;
            bank_nxt = '0;
        end else if (vert) begin
            if (bank == BANK_LAST) begin
                bank_nxt = '0;
                col_nxt = col + 7'h1;
            end else begin
                bank_nxt = bank + 4'h1;
            end
        end else begin
            if (col == COL_LAST) begin
                col_nxt = '0;
                bank_nxt = bank + 4'h1;
            end else begin
                col_nxt = col + 7'h1;
            end
        end
    end
endmodule : lrap_ptr_step

/* lrap_ram_pointer.sv */
// display memory with its address pointer, serial bus slave and column scan port
// What this block does
// - column 0..101, bank 0..8, never beyond
// - vertical mode: bank advances after each byte
// - vertical: past bank 8, bank 0, next column
// - horizontal: past column 101, column 0, next bank
// - after column 101 bank 8, both zero
// - mirror set: address 0 is physical column 101
// - mirror clear: address 0 is physical column 0
// - read-modify-write: advance on writes only
// - eight byte banks plus one single-bit bank
// - mirror clear: each column address drives its own column
// - active-low reset pin resets all registers; display memory is not reset
// - select pin sets bus address low bit
// - bus traffic never disturbs display scanning
// - reads return memory byte or status byte
// - commands executed, display bytes stored
// - data/command bit selects memory; commit at ack
// - answer one of two reserved slave addresses
`timescale 1ns/1ns
module lrap_ram_pointer
    import lrap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic disp_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic bus_addr_select_pin,
    input wire logic read_modify_write_flag,
    output logic [6:0] col_ptr,
    output logic [3:0] bank_ptr,
    output logic mirror_columns_flag,
    output logic vertical_flag,
    output logic power_down,
    output logic [6:0] drv_col,
    output logic [3:0] drv_bank,
    output logic [7:0] drv_data,
    output logic drv_strobe
);
    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    lrap_host_s r;
    lrap_host_s n;
    lrap_disp_s d;
    lrap_disp_s dn;
    logic [7:0] mem_q [MEM_WORDS];

    logic [3:0] ref_sync;
    logic scl_s;
    logic sda_s;
    logic addr_sel_s;
    logic req_s;
    logic ans_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic addr_hit;
    logic ptr_adv;
    logic mem_we;
    logic [9:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [6:0] phys_col;
    logic [9:0] ptr_idx;
    logic [9:0] scan_idx;
    logic [7:0] status_byte;
    logic [7:0] send_byte;
    logic [6:0] step_col;
    logic [3:0] step_bank;

    function automatic logic [9:0] mem_index(input logic [3:0] b, input logic [6:0] c);
        return (10'(b) * MEM_COLS) + 10'(c);
    endfunction : mem_index

    // ------------------------------------------------------------
    // pin and crossing synchronisers
    // ------------------------------------------------------------
    lrap_sync3 #(
        .W(4),
        .INIT(SYNC_IDLE)
    ) u_ref_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .d({d.req_tgl, bus_addr_select_pin, sda_in, scl_in}),
        .q(ref_sync)
    );

    lrap_sync3 #(
        .W(1),
        .INIT(1'b0)
    ) u_disp_sync (
        .clk(disp_clk),
        .reset_n(reset_n),
        .d(r.ans_tgl),
        .q(ans_s)
    );

    assign scl_s = ref_sync[0];
    assign sda_s = ref_sync[1];
    assign addr_sel_s = ref_sync[2];
    assign req_s = ref_sync[3];

    lrap_ptr_step u_step (
        .col(r.col),
        .bank(r.bank),
        .vert(r.vert),
        .col_nxt(step_col),
        .bank_nxt(step_bank)
    );

    // ------------------------------------------------------------
    // bus events and addressing
    // ------------------------------------------------------------
    assign scl_rise = scl_s & ~r.scl_p;
    assign scl_fall = ~scl_s & r.scl_p;
    // start and stop are sda edges while scl stays high
    assign start_ev = r.scl_p & scl_s & r.sda_p & ~sda_s;
    assign stop_ev = r.scl_p & scl_s & ~r.sda_p & sda_s;
    assign addr_hit = (r.sh[7:1] == {SLAVE_ADDR_HI, addr_sel_s});

    assign phys_col = r.mirror ? (COL_LAST - r.col) : r.col;
    assign ptr_idx = mem_index(r.bank, phys_col);
    assign scan_idx = mem_index(d.bank, d.col);
    assign mem_waddr = ptr_idx;
    // the last bank holds a single bit per column
    assign mem_wdata = (r.bank == BANK_LAST) ? (r.sh & LAST_BANK_MASK) : r.sh;

    always_comb begin
        status_byte = '0;
        status_byte[ST_PD_BIT] = r.pd;
        status_byte[ST_MIRROR_BIT] = r.mirror;
        status_byte[ST_MY_BIT] = r.my;
        send_byte = r.dc ? mem_q[ptr_idx] : status_byte;
    end

    // ------------------------------------------------------------
    // bus slave and pointer
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        ptr_adv = 1'b0;
        mem_we = 1'b0;
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        if (start_ev) begin
            n.st = S_ADDR;
            n.cnt = '0;
            n.oe = 1'b0;
            n.ctrl_next = 1'b1;
        end else if (stop_ev) begin
            n.st = S_IDLE;
            n.oe = 1'b0;
        end else begin
            unique case (r.st)
                S_IDLE, S_WAIT: begin
                    n.oe = 1'b0;
                end
                S_ADDR: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == BYTE_BITS) begin
                        if (addr_hit) begin
                            n.rw = r.sh[0];
                            n.oe = 1'b1;
                            n.st = S_AACK;
                        end else begin
                            n.st = S_WAIT;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        n.cnt = '0;
                        if (r.rw) begin
                            // a read answers at once with what the last data/command bit chose
                            n.sh = send_byte;
                            n.oe = ~send_byte[7];
                            n.cnt = 4'h1;
                            n.st = S_SEND;
                        end else begin
                            n.oe = 1'b0;
                            n.st = S_RECV;
                        end
                    end
                end
                S_RECV: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == BYTE_BITS) begin
                        n.oe = 1'b1;
                        n.cnt = '0;
                        n.st = S_RACK;
                        if (r.ctrl_next) begin
                            n.co = r.sh[CTRL_CO_BIT];
                            n.dc = r.sh[CTRL_DC_BIT];
                            n.ctrl_next = 1'b0;
                        end else begin
                            // a cleared continuation bit means data bytes only from here on
                            n.ctrl_next = r.co;
                            if (r.dc) begin
                                mem_we = 1'b1;
                                ptr_adv = 1'b1;
                            end else if (r.sh[7]) begin
                                // out-of-range loads are dropped so the pointer stays legal
                                if (r.sh[6:0] <= COL_LAST) begin
                                    n.col = r.sh[6:0];
                                end
                            end else if (r.sh[7:4] == CMD_SET_BANK) begin
                                if (r.sh[3:0] <= BANK_LAST) begin
                                    n.bank = r.sh[3:0];
                                end
                            end else if (r.sh[7:5] == CMD_FSET) begin
                                n.mirror = r.sh[FS_MIRROR_BIT];
                                n.my = r.sh[FS_MY_BIT];
                                n.pd = r.sh[FS_PD_BIT];
                                n.vert = r.sh[FS_V_BIT];
                            end
                        end
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        n.oe = 1'b0;
                        n.st = S_RECV;
                    end
                end
                S_SEND: begin
                    if (scl_fall) begin
                        if (r.cnt == BYTE_BITS) begin
                            n.oe = 1'b0;
                            n.st = S_MACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe = ~r.sh[6];
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        n.co = ~sda_s;
                        if (r.dc && !read_modify_write_flag) begin
                            ptr_adv = 1'b1;
                        end
                    end else if (scl_fall) begin
                        // a missing master acknowledge ends the read
                        if (r.co) begin
                            n.sh = send_byte;
                            n.oe = ~send_byte[7];
                            n.cnt = 4'h1;
                            n.st = S_SEND;
                        end else begin
                            n.st = S_WAIT;
                        end
                    end
                end
            endcase
        end
        if (ptr_adv) begin
            n.col = step_col;
            n.bank = step_bank;
        end
        // column scan answers on its own path, whatever the bus is doing
        if (req_s != r.req_seen) begin
            n.req_seen = req_s;
            n.ans_data = mem_q[scan_idx];
            n.ans_tgl = ~r.ans_tgl;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    // memory has no reset: contents are undefined until written
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem_q[mem_waddr] <= mem_wdata;
        end
    end

    // ------------------------------------------------------------
    // column scan in the display clock domain
    // ------------------------------------------------------------
    always_comb begin
        dn = d;
        dn.o_stb = 1'b0;
        if (!d.started) begin
            dn.started = 1'b1;
            dn.req_tgl = ~d.req_tgl;
        end else if (ans_s != d.ans_seen) begin
            // ans_data is held still by the handshake, so it is safe to take here
            dn.ans_seen = ans_s;
            dn.o_data = r.ans_data;
            dn.o_col = d.col;
            dn.o_bank = d.bank;
            dn.o_stb = 1'b1;
            dn.req_tgl = ~d.req_tgl;
            if (d.col == COL_LAST) begin
                dn.col = '0;
                dn.bank = (d.bank == BANK_LAST) ? 4'h0 : (d.bank + 4'h1);
            end else begin
                dn.col = d.col + 7'h1;
            end
        end
    end

    always_ff @(posedge disp_clk or negedge reset_n) begin
        if (!reset_n) begin
            d <= DISP_RST;
        end else begin
            d <= dn;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sda_out = SDA_DRIVE_LVL;
    assign sda_oe = r.oe;
    assign col_ptr = r.col;
    assign bank_ptr = r.bank;
    assign mirror_columns_flag = r.mirror;
    assign vertical_flag = r.vert;
    assign power_down = r.pd;
    assign drv_col = d.o_col;
    assign drv_bank = d.o_bank;
    assign drv_data = d.o_data;
    assign drv_strobe = d.o_stb;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_wr_commit;
        mem_we;
    endsequence

    sequence s_ack_held;
        r.oe && (r.st == S_RACK);
    endsequence

    property p_ptr_range;
        @(posedge ref_clk) disable iff (!reset_n)
        (r.col <= COL_LAST) && (r.bank <= BANK_LAST);
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("pointer outside legal range");

    property p_vert_step;
        @(posedge ref_clk) disable iff (!reset_n)
        ptr_adv && r.vert && (r.bank != BANK_LAST) |=> (r.bank == $past(r.bank) + 4'h1) && (r.col == $past(r.col));
    endproperty
    a_vert_step: assert property (p_vert_step) else $error("vertical step wrong");

    property p_vert_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        ptr_adv && r.vert && (r.bank == BANK_LAST) && (r.col != COL_LAST)
            |=> (r.bank == 4'h0) && (r.col == $past(r.col) + 7'h1);
    endproperty
    a_vert_wrap: assert property (p_vert_wrap) else $error("vertical wrap wrong");

    property p_horz_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        ptr_adv && !r.vert && (r.col == COL_LAST) && (r.bank != BANK_LAST)
            |=> (r.col == 7'h0) && (r.bank == $past(r.bank) + 4'h1);
    endproperty
    a_horz_wrap: assert property (p_horz_wrap) else $error("horizontal wrap wrong");

    property p_horz_step;
        @(posedge ref_clk) disable iff (!reset_n)
        ptr_adv && !r.vert && (r.col != COL_LAST) |=> (r.col == $past(r.col) + 7'h1) && (r.bank == $past(r.bank));
    endproperty
    a_horz_step: assert property (p_horz_step) else $error("horizontal step wrong");

    property p_last_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        ptr_adv && (r.col == COL_LAST) && (r.bank == BANK_LAST) |=> (r.col == 7'h0) && (r.bank == 4'h0);
    endproperty
    a_last_wrap: assert property (p_last_wrap) else $error("final location did not wrap");

    property p_mirror_on;
        @(posedge ref_clk) disable iff (!reset_n)
        s_wr_commit ##0 (r.mirror && r.col == 7'h0) |-> (mem_waddr == mem_index(r.bank, COL_LAST));
    endproperty
    a_mirror_on: assert property (p_mirror_on) else $error("mirrored column 0 not at right edge");

    property p_mirror_off;
        @(posedge ref_clk) disable iff (!reset_n)
        s_wr_commit ##0 (!r.mirror && r.col == 7'h0) |-> (mem_waddr == mem_index(r.bank, 7'h0));
    endproperty
    a_mirror_off: assert property (p_mirror_off) else $error("column 0 not at left edge");

    property p_rmw_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (r.st == S_MACK) && scl_rise && read_modify_write_flag |=> $stable(r.col) && $stable(r.bank);
    endproperty
    a_rmw_hold: assert property (p_rmw_hold) else $error("pointer moved on read in rmw mode");

    property p_last_bank_bit;
        @(posedge ref_clk) disable iff (!reset_n)
        mem_we && (r.bank == BANK_LAST) |-> (mem_wdata[7:1] == 7'h00);
    endproperty
    a_last_bank_bit: assert property (p_last_bank_bit) else $error("last bank stored more than one bit");

    property p_commit_ack;
        @(posedge ref_clk) disable iff (!reset_n)
        s_wr_commit |=> s_ack_held;
    endproperty
    a_commit_ack: assert property (p_commit_ack) else $error("write not committed in ack cycle");

    property p_addr_ack;
        @(posedge ref_clk) disable iff (!reset_n)
        (r.st == S_ADDR) && !start_ev && !stop_ev && scl_fall && (r.cnt == BYTE_BITS) && addr_hit
            |=> (r.st == S_AACK) && sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_scan_answer;
        @(posedge disp_clk) disable iff (!reset_n)
        d.started && (ans_s != d.ans_seen) |=> drv_strobe && (d.req_tgl != $past(d.req_tgl));
    endproperty
    a_scan_answer: assert property (p_scan_answer) else $error("scan answer not taken");
endmodule : lrap_ram_pointer

/* lrap_ram_pointer_bench.sv */
// self-checking bench for the display memory pointer block
`timescale 1ns/1ns
module lrap_ram_pointer_bench;
    logic ref_clk = 1'b0;
    logic disp_clk = 1'b0;
    logic reset_n = 1'b0;
    logic rmw = 1'b0;
    logic addr_sel = 1'b0;
    logic scl, pull, sda_oe, mirror, vf, stb, k, a, pd;
    logic [6:0] drv_col;
    logic [3:0] drv_bank;
    logic [7:0] drv_data;
    logic [7:0] scan_q;
    logic [6:0] col_ptr;
    logic [3:0] bank_ptr;
    logic [7:0] q;
    wire sda_line = ~(sda_oe | pull);
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int strobes = 0;
    int scan_hits = 0;
    always #5 ref_clk = ~ref_clk;
    // offset start keeps the scan clock out of phase with the system clock
    initial #1 forever #3 disp_clk = ~disp_clk;
    // sampled mid-cycle, away from the edge that launches the scan outputs
    always @(negedge disp_clk) begin
        if (stb === 1'b1) strobes++;
        if (stb === 1'b1 && drv_col === 7'h65 && drv_bank === 4'h0) begin
            scan_q = drv_data;
            scan_hits++;
        end
    end
    lrap_ram_pointer dut (.ref_clk(ref_clk), .reset_n(reset_n), .disp_clk(disp_clk), .scl_in(scl),
        .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .bus_addr_select_pin(addr_sel),
        .read_modify_write_flag(rmw), .col_ptr(col_ptr), .bank_ptr(bank_ptr), .mirror_columns_flag(mirror),
        .vertical_flag(vf), .power_down(pd), .drv_col(drv_col), .drv_bank(drv_bank), .drv_data(drv_data),
        .drv_strobe(stb));
    lrap_host_model m (.clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_pull(pull));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic test_done();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // reads clock out n bytes and refuse the last; writes send a control byte first
    task automatic frame(input logic [7:0] ad, input logic [7:0] c, input logic [7:0] d, input int n);
        m.start();
        m.xbyte(ad, 1'b1, q, a);
        if (!ad[0]) m.xbyte(c, 1'b1, q, k);
        for (int i = 0; i < n; i++) m.xbyte(ad[0] ? 8'hFF : d + i[7:0], ad[0] ? (i == n - 1) : 1'b1, q, k);
        m.stop();
    endtask : frame
    task automatic cmd(input logic [7:0] c);
        frame(8'h78, 8'h00, c, 1);
    endtask : cmd
    task automatic rd(input logic dc);
        frame(8'h78, {1'b0, dc, 6'h00}, 8'h00, 0);
        frame(8'h79, 8'h00, 8'h00, 1);
    endtask : rd
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_walk();
        chk({col_ptr, bank_ptr}, 11'h000);
        cmd(8'h22);
        cmd(8'hE5);
        cmd(8'h47);
        frame(8'h78, 8'h40, 8'hA5, 3);
        chk({col_ptr, bank_ptr}, {7'h00, 4'h1});
        cmd(8'h85);
        cmd(8'h48);
        frame(8'h78, 8'h40, 8'h11, 1);
        chk({col_ptr, bank_ptr}, {7'h06, 4'h0});
        cmd(8'h20);
        cmd(8'hE4);
        cmd(8'h40);
        frame(8'h78, 8'h40, 8'h22, 2);
        chk({col_ptr, bank_ptr}, {7'h00, 4'h1});
        cmd(8'hE6);
        chk({col_ptr, bank_ptr}, {7'h00, 4'h1});
        chk({10'h000, vf}, 11'h000);
    endtask : t_walk
    task automatic t_read();
        cmd(8'hE5);
        cmd(8'h40);
        frame(8'h78, 8'h40, 8'h3C, 1);
        cmd(8'h80);
        cmd(8'h34);
        cmd(8'h40);
        @(negedge ref_clk) rmw = 1'b1;
        rd(1'b1);
        chk({3'h0, q}, 11'h03C);
        chk({10'h000, mirror}, 11'h001);
        chk({col_ptr, bank_ptr}, {7'h00, 4'h0});
        @(negedge ref_clk) rmw = 1'b0;
        rd(1'b1);
        chk({col_ptr, bank_ptr}, {7'h01, 4'h0});
        rd(1'b0);
        chk({3'h0, q}, 11'h084);
        chk({10'h000, pd}, 11'h001);
        cmd(8'h80);
        cmd(8'h42);
        frame(8'h78, 8'h40, 8'h5A, 1);
        cmd(8'h20);
        cmd(8'hE5);
        cmd(8'h42);
        rd(1'b1);
        chk({3'h0, q}, 11'h05A);
    endtask : t_read
    task automatic t_addr();
        int h = scan_hits;
        @(negedge ref_clk) addr_sel = 1'b1;
        m.wt(10);
        frame(8'h78, 8'h00, 8'h00, 0);
        chk({10'h000, a}, 11'h001);
        frame(8'h7A, 8'h00, 8'h00, 0);
        chk({10'h000, a}, 11'h000);
        chk({10'h000, strobes > 0}, 11'h001);
        // a full scan lap takes thousands of cycles, so wait for a fresh pass over that column
        for (int i = 0; i < 12000 && scan_hits == h; i++) @(negedge ref_clk);
        chk({3'h0, scan_q}, 11'h03C);
    endtask : t_addr
    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        t_walk();
        t_read();
        t_addr();
        test_done();
    end
endmodule : lrap_ram_pointer_bench

/* lrap_sync3.sv */
// three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ns
module lrap_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } lrap_sync_s;

    lrap_sync_s r_q;
    lrap_sync_s r_d;

    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        // s1 is only read by s2; the filter looks at the later stages
        for (int i = 0; i < W; i++) begin
            if (r_q.s2[i] == r_q.s3[i]) begin
                r_d.lvl[i] = r_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.lvl;
endmodule : lrap_sync3
